// ---- rtl/eeprom_byte_access.sv ----
// byte-wide nonvolatile store controller with an ahb-lite register port
`timescale 1ns/1ns
`include "nv_store_defines.svh"

module eeprom_byte_access
  import nv_store_pkg::*;
#(
  parameter int WRITE_CYCLES = `NV_WRITE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic selfprog_active,
  input wire logic global_irq_enable,
  output logic nv_ready_irq,
  output logic irq
);

  // ------------------------------------------------------------
  // storage and state
  // ------------------------------------------------------------
  logic [7:0] mem [0:`NV_DEPTH-1];
  ahb_phase_t ap_r;
  nv_state_t state_r;
  nv_write_t pend_r;
  logic [`NV_ADDR_W-1:0] pointer_r;
  logic [7:0] value_r;
  logic ready_en_r;
  logic [2:0] arm_cnt_r;
  logic [2:0] stall_cnt_r;
  logic [19:0] wr_cnt_r;
  logic [`NV_EV_COUNT-1:0] status_r;
  logic [`NV_EV_COUNT-1:0] mask_r;
  logic [31:0] hrdata_r;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire logic busy = (state_r == ST_WRITING);
  wire logic arm_active = (arm_cnt_r != 3'h0);
  wire logic addr_take = hsel && hready && htrans[1];
  wire logic do_access = ap_r.valid && (stall_cnt_r == 3'h0);
  wire logic do_write = do_access && ap_r.write;
  wire logic ctrl_wr = do_write && (ap_r.addr == `NV_CONTROL_OFS);
  wire logic ptr_wr = do_write && (ap_r.addr == `NV_BYTE_POINTER_OFS);
  wire logic val_wr = do_write && (ap_r.addr == `NV_BYTE_VALUE_OFS);
  wire logic stat_wr = do_write && (ap_r.addr == `NV_IRQ_STATUS_OFS);
  wire logic mask_wr = do_write && (ap_r.addr == `NV_IRQ_MASK_OFS);

  // ------------------------------------------------------------
  // control strobes
  // ------------------------------------------------------------
  // arming only counts when go is written zero in the same access
  wire logic arm_set = ctrl_wr && hwdata[`NV_WRITE_ARM_BIT] &&
                       !hwdata[`NV_WRITE_GO_BIT];
  // go needs a live arm, an idle engine and no self-programming
  wire logic go_start = ctrl_wr && hwdata[`NV_WRITE_GO_BIT] && arm_active &&
                        !busy && !selfprog_active;
  wire logic rd_go = ctrl_wr && hwdata[`NV_READ_GO_BIT] && !busy && !go_start;
  wire logic stall_start = go_start || rd_go;
  wire logic arm_lapse = (arm_cnt_r == 3'h1) && !go_start && !arm_set;
  wire logic write_end = busy && (wr_cnt_r == 20'h00001);
  wire logic [`NV_EV_COUNT-1:0] ev_set = {rd_go, arm_lapse, write_end};

  // the wait states start in the very data phase that triggers them
  assign hreadyout = (stall_cnt_r == 3'h0) && !stall_start;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // ------------------------------------------------------------
  // read mux, evaluated in the address phase
  // ------------------------------------------------------------
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    case (a)
      `NV_CONTROL_OFS: reg_read = {28'h0000000, ready_en_r, arm_active, busy, 1'b0};
      `NV_BYTE_POINTER_OFS: reg_read = {23'h000000, pointer_r};
      `NV_BYTE_VALUE_OFS: reg_read = {24'h000000, value_r};
      `NV_IRQ_STATUS_OFS: reg_read = {29'h00000000, status_r};
      `NV_IRQ_MASK_OFS: reg_read = {29'h00000000, mask_r};
      default: reg_read = 32'h00000000;
    endcase
  endfunction

  // ------------------------------------------------------------
  // address phase capture and read data
  // ------------------------------------------------------------
  // the phase is dropped once handled so a stall never repeats its effect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r <= '0;
      hrdata_r <= 32'h00000000;
    end else if (hreadyout) begin
      ap_r <= '{valid: addr_take, write: hwrite, addr: haddr[7:0]};
      if (addr_take && !hwrite) begin
        hrdata_r <= reg_read(haddr[7:0]);
      end
    end else if (do_access) begin
      ap_r.valid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // wait state counter
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stall_cnt_r <= 3'h0;
    end else if (go_start) begin
      stall_cnt_r <= `NV_WRITE_STALL_CYCLES - 3'h1;
    end else if (rd_go) begin
      stall_cnt_r <= `NV_READ_STALL_CYCLES - 3'h1;
    end else if (stall_cnt_r != 3'h0) begin
      stall_cnt_r <= stall_cnt_r - 3'h1;
    end
  end

  // ------------------------------------------------------------
  // arm window
  // ------------------------------------------------------------
  // a consumed arm leaves no trace and a lapsed one only its status event, so a late go is harmless
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_cnt_r <= 3'h0;
    end else if (arm_set) begin
      arm_cnt_r <= `NV_ARM_WINDOW_CYCLES;
    end else if (go_start) begin
      arm_cnt_r <= 3'h0;
    end else if (arm_active) begin
      arm_cnt_r <= arm_cnt_r - 3'h1;
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pointer_r <= `NV_POINTER_RESET;
      ready_en_r <= 1'b0;
      mask_r <= `NV_MASK_RESET;
    end else begin
      if (ptr_wr && !busy) begin
        pointer_r <= hwdata[`NV_ADDR_W-1:0];
      end
      if (ctrl_wr) begin
        ready_en_r <= hwdata[`NV_READY_IRQ_ENABLE_BIT];
      end
      if (mask_wr) begin
        mask_r <= hwdata[`NV_EV_COUNT-1:0];
      end
    end
  end

  // value register: bus writes, or the addressed byte on read-go
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_r <= 8'h00;
    end else if (rd_go) begin
      value_r <= mem[pointer_r];
    end else if (val_wr) begin
      value_r <= hwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // write engine
  // ------------------------------------------------------------
  // pointer and value are copied at go, so later bus writes cannot
  // disturb a write in flight
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      pend_r <= '0;
      wr_cnt_r <= 20'h00000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (go_start) begin
            state_r <= ST_WRITING;
            pend_r <= '{addr: pointer_r, data: value_r};
            wr_cnt_r <= WRITE_CYCLES[19:0];
          end
        end
        ST_WRITING: begin
          wr_cnt_r <= wr_cnt_r - 20'h00001;
          if (write_end) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // the array has no reset: its contents survive a reset
  always_ff @(posedge hclk) begin
    if (write_end) begin
      mem[pend_r.addr] <= pend_r.data;
    end
  end

  // ------------------------------------------------------------
  // event status, write one to clear; a new event beats the clear
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~(stat_wr ? hwdata[`NV_EV_COUNT-1:0] : 3'h0)) | ev_set;
    end
  end

  // ------------------------------------------------------------
  // interrupt outputs
  // ------------------------------------------------------------
  // level ready request: up while its enable and the global enable are set and no write is running
  assign nv_ready_irq = ready_en_r && global_irq_enable && !busy;
  assign irq = |(status_r & mask_r);

endmodule

// ---- rtl/nv_store_defines.svh ----
// register map, field positions, reset values and timing counts of the byte store
`ifndef NV_STORE_DEFINES_SVH
`define NV_STORE_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define NV_CONTROL_OFS 8'h00
`define NV_BYTE_POINTER_OFS 8'h04
`define NV_BYTE_VALUE_OFS 8'h08
`define NV_IRQ_STATUS_OFS 8'h0C
`define NV_IRQ_MASK_OFS 8'h10

// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define NV_READ_GO_BIT 0
`define NV_WRITE_GO_BIT 1
`define NV_WRITE_ARM_BIT 2
`define NV_READY_IRQ_ENABLE_BIT 3

// ------------------------------------------------------------
// event bits in status and mask
// ------------------------------------------------------------
`define NV_EV_WRITE_DONE 0
`define NV_EV_ARM_LAPSED 1
`define NV_EV_READ_DONE 2
`define NV_EV_COUNT 3

// ------------------------------------------------------------
// sizes, reset values and timing
// ------------------------------------------------------------
`define NV_DEPTH 512
`define NV_ADDR_W 9
`define NV_POINTER_RESET 9'h000
`define NV_MASK_RESET 3'h0
`define NV_ARM_WINDOW_CYCLES 3'h4
`define NV_READ_STALL_CYCLES 3'h4
`define NV_WRITE_STALL_CYCLES 3'h2
`define NV_WRITE_OSC_CYCLES 27072
`define NV_WRITE_TIME_NS 3300000
`define NV_CLK_PERIOD_NS 8
`define NV_WRITE_CYCLES (`NV_WRITE_TIME_NS / `NV_CLK_PERIOD_NS)

`endif

// ---- rtl/nv_store_pkg.sv ----
// types shared by the byte store controller
package nv_store_pkg;

  // ------------------------------------------------------------
  // write engine states
  // ------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WRITING = 1'b1
  } nv_state_t;

  // ------------------------------------------------------------
  // captured bus address phase
  // ------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_phase_t;

  // ------------------------------------------------------------
  // pending write: location and byte
  // ------------------------------------------------------------
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } nv_write_t;

endpackage

// ---- verification/eeprom_byte_access_checker.sv ----
// assertion checker for the byte store controller, bound to its ports
`timescale 1ns/1ns
`include "nv_store_defines.svh"
module eeprom_byte_access_checker
  import nv_store_pkg::*;
#(
  parameter int WRITE_CYCLES = `NV_WRITE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic selfprog_active,
  input wire logic global_irq_enable,
  input wire logic nv_ready_irq,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------------------
  // data-phase tracking
  // ------------------------------------------------------------
  ahb_phase_t ph_r;
  logic hro_q;
  int busy_cnt;
  logic [3:0] arm_age;
  wire ctl_wr = ph_r.valid && ph_r.write && ph_r.addr == `NV_CONTROL_OFS;
  wire rd_ph = ph_r.valid && !ph_r.write;
  wire go = hwdata[`NV_WRITE_GO_BIT];
  wire rgo = hwdata[`NV_READ_GO_BIT];
  wire mapped = ph_r.addr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  // busy window counted short of the real write, so its far end never matters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= '0;
      hro_q <= 1'b1;
      busy_cnt <= 0;
      arm_age <= 4'hF;
    end else begin
      if (hready) ph_r <= '{valid: hsel && htrans[1], write: hwrite, addr: haddr[7:0]};
      hro_q <= hreadyout;
      if (ctl_wr && hro_q && !hreadyout && go) busy_cnt <= WRITE_CYCLES - 6;
      else if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
      if (ctl_wr && hreadyout && hwdata[2] && !go) arm_age <= 4'h0;
      else if (arm_age != 4'hF) arm_age <= arm_age + 4'h1;
    end
  end
  AST_OKAY: assert property (hresp == 1'b0) else $error("slave answered not OKAY");
  AST_READ_STALL: assert property ($fell(hreadyout) && ctl_wr && rgo && !go
    |-> !hreadyout [*4] ##1 hreadyout) else $error("read stall not four cycles");
  AST_WRITE_STALL: assert property ($fell(hreadyout) && ctl_wr && go
    |-> !hreadyout [*2] ##1 hreadyout) else $error("write stall not two cycles");
  AST_STALL_CAUSE: assert property (!hreadyout |-> ctl_wr && (rgo || go))
    else $error("wait state without a go");
  AST_BUSY_REFUSE: assert property (busy_cnt != 0 && busy_cnt < WRITE_CYCLES - 8
    |-> hreadyout) else $error("stall while write busy");
  AST_BUSY_NO_READY: assert property (busy_cnt != 0 && busy_cnt < WRITE_CYCLES - 8
    |-> !nv_ready_irq) else $error("ready irq while busy");
  AST_READY_GATE: assert property (!global_irq_enable |-> !nv_ready_irq)
    else $error("ready irq with global enable off");
  AST_NO_ARM: assert property (ctl_wr && go && !rgo && arm_age == 4'hF |-> hreadyout)
    else $error("go without arm stalled");
  AST_SELFPROG: assert property (ctl_wr && go && !rgo && selfprog_active |-> hreadyout)
    else $error("write started during self-programming");
  AST_UNMAPPED: assert property (rd_ph && !mapped |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_PTR_WIDTH: assert property (rd_ph && ph_r.addr == `NV_BYTE_POINTER_OFS
    |-> hrdata[31:9] == 23'h0) else $error("pointer upper bits set");
endmodule

bind eeprom_byte_access eeprom_byte_access_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .selfprog_active(selfprog_active),
  .global_irq_enable(global_irq_enable), .nv_ready_irq(nv_ready_irq), .irq(irq));

// ---- verification/eeprom_byte_access_test.sv ----
// self-checking bench for the byte store controller over its bus port
`timescale 1ns/1ns
module eeprom_byte_access_test
  import nv_store_pkg::*;
;
  localparam logic [7:0] CTL = 8'h00, PTR = 8'h04, VAL = 8'h08, STS = 8'h0C, MSK = 8'h10;
  logic hclk, hresetn, hsel, hwrite, selfprog_active, global_irq_enable;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rd_q, waits;
  wire hreadyout, hresp, nv_ready_irq, irq;
  wire [31:0] hrdata;
  int mismatches, tests_run;
  eeprom_byte_access #(.WRITE_CYCLES(20)) eeprom_byte_access_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .selfprog_active(selfprog_active),
    .global_irq_enable(global_irq_enable), .nv_ready_irq(nv_ready_irq), .irq(irq));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ready is looked at before the edge, so the decision never races that edge
  task automatic wait_ready(output logic [31:0] n);
    logic ok;
    n = 0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge hclk);
      ok = (hreadyout === 1'b1);
      rd_q = hrdata;
      @(posedge hclk);
      if (!ok) n = n + 1;
      if (n > 50) begin
        mismatches++;
        give_verdict();
      end
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_ready(n);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready(waits);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd_q, exp);
  endtask
  task automatic poll_idle;
    int k;
    k = 0;
    rd_q = 32'h2;
    while (rd_q[1] !== 1'b0 && k < 100) begin
      xfer(1'b0, CTL, 32'h0);
      k++;
    end
    if (k == 100) begin
      mismatches++;
      give_verdict();
    end
  endtask
  task automatic fetch(input logic [8:0] p, input logic [7:0] v);
    xfer(1'b1, PTR, {23'h0, p});
    xfer(1'b1, CTL, 32'h1);
    check(waits, 32'h4);
    rdc(VAL, {24'h0, v});
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, selfprog_active, htrans, haddr, hwdata} = '0;
    {rd_q, waits, mismatches, tests_run} = '0;
    global_irq_enable = 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, then an unmapped place
    rdc(CTL, 32'h0);
    rdc(PTR, 32'h0);
    rdc(VAL, 32'h0);
    rdc(8'h14, 32'h0);
    // go with no arm, then a lapsed arm: neither may stall
    xfer(1'b1, CTL, 32'h2);
    check(waits, 32'h0);
    xfer(1'b1, CTL, 32'h4);
    repeat (6) @(posedge hclk);
    xfer(1'b1, CTL, 32'h2);
    check(waits, 32'h0);
    rdc(STS, 32'h2);
    xfer(1'b1, STS, 32'h7);
    xfer(1'b1, PTR, 32'hFFFFFFFF);
    rdc(PTR, 32'h1FF);
    // first write, poking at the store while it runs
    xfer(1'b1, VAL, 32'hA5);
    xfer(1'b1, CTL, 32'h4);
    xfer(1'b1, CTL, 32'h2);
    check(waits, 32'h2);
    xfer(1'b0, CTL, 32'h0);
    check(rd_q & 32'hB, 32'h2);
    xfer(1'b1, PTR, 32'h10);
    rdc(PTR, 32'h1FF);
    xfer(1'b1, CTL, 32'h1);
    check(waits, 32'h0);
    xfer(1'b1, VAL, 32'h3C);
    poll_idle();
    xfer(1'b0, STS, 32'h0);
    check(rd_q & 32'h1, 32'h1);
    // level interrupt follows status and mask; levels are looked at mid-cycle,
    // and the next drive waits for a rising edge so no request starts off-edge
    xfer(1'b1, MSK, 32'h1);
    @(negedge hclk);
    check({31'h0, irq}, 32'h1);
    @(posedge hclk);
    xfer(1'b1, STS, 32'h7);
    @(negedge hclk);
    check({31'h0, irq}, 32'h0);
    @(posedge hclk);
    fetch(9'h1FF, 8'hA5);
    rdc(STS, 32'h4);
    // ready interrupt, then a second byte written with it enabled
    xfer(1'b1, CTL, 32'h8);
    @(negedge hclk);
    check({31'h0, nv_ready_irq}, 32'h1);
    @(posedge hclk);
    global_irq_enable <= 1'b0;
    @(negedge hclk);
    check({31'h0, nv_ready_irq}, 32'h0);
    @(posedge hclk);
    global_irq_enable <= 1'b1;
    xfer(1'b1, PTR, 32'h0);
    xfer(1'b1, VAL, 32'h5A);
    xfer(1'b1, CTL, 32'hC);
    xfer(1'b1, CTL, 32'hA);
    repeat (3) @(posedge hclk);
    check({31'h0, nv_ready_irq}, 32'h0);
    poll_idle();
    check({31'h0, nv_ready_irq}, 32'h1);
    fetch(9'h000, 8'h5A);
    fetch(9'h1FF, 8'hA5);
    // self-programming blocks the start
    selfprog_active <= 1'b1;
    xfer(1'b1, CTL, 32'h4);
    xfer(1'b1, CTL, 32'h2);
    check(waits, 32'h0);
    // the refused go leaves the arm window running, so only the arm bit reads one
    rdc(CTL, 32'h4);
    give_verdict();
  end
endmodule
